// ---- core/xpt_pkg.sv ----
// Constants shared by the crosspoint programming logic
package xpt_pkg;
  localparam int NUM_OUT      = 16;
  localparam int NUM_IN       = 16;
  localparam int SEL_W        = 4;
  localparam int GRP_W        = 5;
  localparam int WORD_W       = 80;
  localparam int EN_POS       = 0;
  localparam int ADDR_W       = 4;
  localparam int SEL_LSB      = 0;
  localparam logic [SEL_W-1:0] SEL_RST = 4'h0;
endpackage

// ---- core/xpt_matrix.sv ----
// Update latch rank and per-output decode onto one-hot crosspoint controls
`timescale 1ns/1ps
module xpt_matrix (
  input  wire logic                                    CLK,
  input  wire logic                                    SRST,
  input  wire logic                                    ce,
  input  wire logic                                    load,
  input  wire logic                                    rst_outputs,
  input  wire logic [xpt_pkg::WORD_W-1:0]              word,
  output logic [xpt_pkg::NUM_OUT*xpt_pkg::NUM_IN-1:0]  points,
  output logic [xpt_pkg::NUM_OUT-1:0]                  enables
);
  logic [xpt_pkg::WORD_W-1:0] latch_r;
  logic                       forced_off_r;

  // Select LSB is shifted first, so it sits at the top of its group
  function automatic logic [xpt_pkg::SEL_W-1:0] sel_of(input logic [xpt_pkg::WORD_W-1:0] w,
                                                      input int o);
    logic [xpt_pkg::SEL_W-1:0] s;
    for (int k = 0; k < xpt_pkg::SEL_W; k++) begin
      s[k] = w[o*xpt_pkg::GRP_W + xpt_pkg::GRP_W-1-k];
    end
    return s;
  endfunction

  // Holds last word while load is low, so shifting never disturbs the matrix
  always_ff @(posedge CLK) begin
    if (SRST) begin
      latch_r <= '0;
    end else if (ce && load) begin
      latch_r <= word;
    end
  end

  // Reset clears enables only; stored word stays put
  always_ff @(posedge CLK) begin
    if (SRST) begin
      forced_off_r <= 1'b1;
    end else if (ce) begin
      if (rst_outputs) begin
        forced_off_r <= 1'b1;
      end else if (load) begin
        forced_off_r <= 1'b0;
      end
    end
  end

  always_comb begin
    points  = '0;
    enables = '0;
    for (int o = 0; o < xpt_pkg::NUM_OUT; o++) begin
      if (!forced_off_r && latch_r[o*xpt_pkg::GRP_W+xpt_pkg::EN_POS]) begin
        enables[o] = 1'b1;
        points[o*xpt_pkg::NUM_IN +
               int'(sel_of(latch_r, o))] = 1'b1;
      end
    end
  end
endmodule

// ---- core/xpt_program.sv ----
// Programming front end of the 16x16 crosspoint switch
// Summary of operation
// - Each output routes from any one of 16 inputs, or none.
// - Disabled outputs are high impedance.
// - Load a first rank, then one global latch applies all settings.
// - Reset input disables all outputs.
// - Serial mode takes one 80-bit word reprogramming the whole matrix.
// - Parallel mode changes one output without reloading others.
// - Data clocks in and latches only while chip select is low.
// - Update low while shifting passes every intermediate state.
// - Serial input sampled on every falling interface clock edge while selected in serial mode.
// - Five bits per output: four select bits then enable bit.
// - Enable bit low disables the output, select bits ignored.
// - Update and chip select low make the latch transparent.
// - Shifted-through data appears on serial output for chaining.
// - Parallel falling edge with update high writes five data lines into addressed slot; with update low it writes nothing.
// - Reset disables outputs, leaving registers unchanged.
// - First serial bit reaches serial output 80 edges later.
`timescale 1ns/1ps
module xpt_program (
  input  wire logic                                    CLK,
  input  wire logic                                    SRST,
  input  wire logic                                    CLK_EN,
  input  wire logic                                    SCLK,
  input  wire logic                                    DATA_IN,
  input  wire logic                                    CHIP_SEL_N,
  input  wire logic                                    UPDATE_N,
  input  wire logic                                    RESET_N,
  input  wire logic                                    MODE_SELECT_SERIAL_LOW,
  input  wire logic [xpt_pkg::ADDR_W-1:0]              OUTPUT_ADDRESS_LINES,
  input  wire logic [xpt_pkg::SEL_W-1:0]               INPUT_SELECT_BITS,
  input  wire logic                                    OUTPUT_ENABLE_BIT,
  output logic                                         DATA_OUT,
  output logic [xpt_pkg::NUM_OUT*xpt_pkg::NUM_IN-1:0]  POINTS,
  output logic [xpt_pkg::NUM_OUT-1:0]                  OUT_ENABLE
);
  localparam int SYNC_W = 9 + xpt_pkg::ADDR_W + xpt_pkg::SEL_W;
  // Idle pin levels: clock, select, update and reset high, so no false edge after reset
  localparam logic [SYNC_W-1:0] SYNC_IDLE = 17'h17000;

  // Builds one stored group: enable at its own slot, select bits LSB on top
  function automatic logic [xpt_pkg::GRP_W-1:0] grp_pack(input logic en,
                                                        input logic [xpt_pkg::SEL_W-1:0] s);
    logic [xpt_pkg::GRP_W-1:0] g;
    g = '0;
    g[xpt_pkg::EN_POS] = en;
    for (int k = 0; k < xpt_pkg::SEL_W; k++) begin
      g[xpt_pkg::GRP_W-1-k] = s[k];
    end
    return g;
  endfunction

  // One output lane: at most one point, and enabled exactly when routed
  function automatic logic route_ok(input logic [xpt_pkg::NUM_IN-1:0] p, input logic e);
    int n;
    n = 0;
    for (int i = 0; i < xpt_pkg::NUM_IN; i++) begin
      n = n + int'(p[i]);
    end
    return (n <= 1) && (e == (n == 1));
  endfunction

  // Two-stage synchronisers; stage one feeds only stage two
  logic [SYNC_W-1:0] sync1_r;
  logic [SYNC_W-1:0] sync2_r;
  logic              sclk_d_r;
  logic [xpt_pkg::WORD_W-1:0] shift_r;
  logic              dout_r;
  logic [xpt_pkg::NUM_OUT*xpt_pkg::NUM_IN-1:0] points_c;
  logic [xpt_pkg::NUM_OUT-1:0] en_c;
  logic [xpt_pkg::NUM_OUT*xpt_pkg::NUM_IN-1:0] points_r;
  logic [xpt_pkg::NUM_OUT-1:0] en_r;

  always_ff @(posedge CLK) begin
    if (SRST) begin
      sync1_r <= SYNC_IDLE;
      sync2_r <= SYNC_IDLE;
    end else if (CLK_EN) begin
      sync1_r <= {SCLK, DATA_IN, CHIP_SEL_N, UPDATE_N, RESET_N, MODE_SELECT_SERIAL_LOW,
                  OUTPUT_ENABLE_BIT, 2'h0, OUTPUT_ADDRESS_LINES, INPUT_SELECT_BITS};
      sync2_r <= sync1_r;
    end
  end

  logic                        s_clk;
  logic                        s_din;
  logic                        s_cs_n;
  logic                        s_upd_n;
  logic                        s_rst_n;
  logic                        s_par;
  logic                        s_en;
  logic [xpt_pkg::ADDR_W-1:0]  s_addr;
  logic [xpt_pkg::SEL_W-1:0]   s_sel;
  logic                        fall;
  logic                        selected;

  assign s_clk   = sync2_r[SYNC_W-1];
  assign s_din   = sync2_r[SYNC_W-2];
  assign s_cs_n  = sync2_r[SYNC_W-3];
  assign s_upd_n = sync2_r[SYNC_W-4];
  assign s_rst_n = sync2_r[SYNC_W-5];
  assign s_par   = sync2_r[SYNC_W-6];
  assign s_en    = sync2_r[SYNC_W-7];
  assign s_addr  = sync2_r[xpt_pkg::SEL_W +: xpt_pkg::ADDR_W];
  assign s_sel   = sync2_r[0 +: xpt_pkg::SEL_W];
  assign fall    = sclk_d_r && !s_clk;
  assign selected = !s_cs_n;

  always_ff @(posedge CLK) begin
    if (SRST) begin
      sclk_d_r <= 1'b1;
    end else if (CLK_EN) begin
      sclk_d_r <= s_clk;
    end
  end

  // Shift register; serial enters at bit 0 so the highest group lands on top
  always_ff @(posedge CLK) begin
    if (SRST) begin
      shift_r <= '0;
    end else if (CLK_EN && fall && selected) begin
      if (!s_par) begin
        shift_r <= {shift_r[xpt_pkg::WORD_W-2:0], s_din};
      end else if (s_upd_n) begin
        shift_r[int'(s_addr)*xpt_pkg::GRP_W +: xpt_pkg::GRP_W] <= grp_pack(s_en, s_sel);
      end
    end
  end

  // Bit that leaves the top is the one shifted in 80 edges earlier
  always_ff @(posedge CLK) begin
    if (SRST) begin
      dout_r <= 1'b0;
    end else if (CLK_EN && fall && selected && !s_par) begin
      dout_r <= shift_r[xpt_pkg::WORD_W-1];
    end
  end

  // Update low keeps latching every cycle, so intermediate shift states pass
  xpt_matrix u_matrix (
    .CLK         (CLK),
    .SRST        (SRST),
    .ce          (CLK_EN),
    .load        (selected && !s_upd_n),
    .rst_outputs (!s_rst_n),
    .word        (shift_r),
    .points      (points_c),
    .enables     (en_c)
  );

  always_ff @(posedge CLK) begin
    if (SRST) begin
      points_r <= '0;
      en_r     <= '0;
    end else if (CLK_EN) begin
      points_r <= points_c;
      en_r     <= en_c;
    end
  end

  logic routes_ok_c;

  always_comb begin
    routes_ok_c = 1'b1;
    for (int o = 0; o < xpt_pkg::NUM_OUT; o++) begin
      if (!route_ok(points_r[o*xpt_pkg::NUM_IN +: xpt_pkg::NUM_IN], en_r[o])) begin
        routes_ok_c = 1'b0;
      end
    end
  end

  assign DATA_OUT   = dout_r;
  assign POINTS     = points_r;
  assign OUT_ENABLE = en_r;

  reset_off_a: assert property (@(posedge CLK) disable iff (SRST)
    (CLK_EN && !s_rst_n) |=> ##1 (!CLK_EN || en_r == '0))
    else $error("outputs enabled after reset input");
  idle_hold_a: assert property (@(posedge CLK) disable iff (SRST)
    (CLK_EN && !selected) |=> $stable(shift_r))
    else $error("shift register changed while deselected");
  serial_shift_a: assert property (@(posedge CLK) disable iff (SRST)
    (CLK_EN && fall && selected && !s_par) |=> shift_r[0] == $past(s_din))
    else $error("serial bit not captured");
  serial_out_a: assert property (@(posedge CLK) disable iff (SRST)
    (CLK_EN && fall && selected && !s_par)
      |=> dout_r == $past(shift_r[xpt_pkg::WORD_W-1]))
    else $error("serial output wrong");
  par_write_a: assert property (@(posedge CLK) disable iff (SRST)
    (CLK_EN && fall && selected && s_par && s_upd_n)
      |=> shift_r[int'($past(s_addr))*xpt_pkg::GRP_W +: xpt_pkg::GRP_W]
          == grp_pack($past(s_en), $past(s_sel)))
    else $error("parallel slot not written");
  par_keep_a: assert property (@(posedge CLK) disable iff (SRST)
    (CLK_EN && fall && selected && s_par && s_upd_n && s_addr != '0)
      |=> $stable(shift_r[xpt_pkg::GRP_W-1:0]))
    else $error("parallel write disturbed another slot");
  par_dout_a: assert property (@(posedge CLK) disable iff (SRST)
    (CLK_EN && s_par) |=> $stable(dout_r))
    else $error("serial output moved in parallel mode");
  out_hold_a: assert property (@(posedge CLK) disable iff (SRST)
    (CLK_EN && (s_cs_n || s_upd_n) && s_rst_n) |=> ##1 (!CLK_EN || $stable(en_r)))
    else $error("outputs changed without update");
  all_lanes_a: assert property (@(posedge CLK) disable iff (SRST)
    routes_ok_c)
    else $error("output routing not one-hot");
  onehot_out_a: assert property (@(posedge CLK) disable iff (SRST)
    $onehot0(points_r[xpt_pkg::NUM_IN-1:0]) &&
    (en_r[0] == |points_r[xpt_pkg::NUM_IN-1:0]))
    else $error("output zero routing not one-hot");
endmodule

// ---- dv/xpt_host.sv ----
// Host controller model driving the programming pins
`timescale 1ns/1ps
module xpt_host (
  input  wire logic  clk,
  output logic       sclk = 1'b1,
  output logic       sdata = 1'b0,
  output logic       cs_n = 1'b1,
  output logic       upd_n = 1'b1,
  output logic       mode = 1'b0,
  output logic [3:0] addr = 4'h0,
  output logic [4:0] pdata = 5'h00
);
  task automatic sel(input logic v);
    @(negedge clk);
    cs_n = v;
  endtask
  // Pin held 4 and 6 cycles so the synchronisers see each level
  task automatic fall();
    repeat (4) @(negedge clk);
    sclk = 1'b0;
    repeat (6) @(negedge clk);
    sclk = 1'b1;
  endtask
  task automatic shift(input logic d);
    mode = 1'b0;
    sdata = d;
    fall();
    sdata = ~d;
  endtask
  task automatic par(input logic [3:0] a, input logic [4:0] v);
    mode = 1'b1;
    addr = a;
    pdata = v;
    fall();
    mode = 1'b0;
    pdata = ~v;
  endtask
  task automatic update();
    upd_n = 1'b0;
    repeat (8) @(negedge clk);
    upd_n = 1'b1;
  endtask
endmodule

// ---- dv/xpt_program_bench.sv ----
// Self-checking bench for the crosspoint programming front end
`timescale 1ns/1ps
module xpt_program_bench;
  logic         CLK = 1'b0;
  logic         SRST = 1'b1;
  logic         RESET_N = 1'b1;
  wire logic    sclk, sdata, cs_n, upd_n, mode;
  wire logic [3:0] addr;
  wire logic [4:0] pdata;
  logic         DATA_OUT;
  logic [255:0] POINTS;
  logic [15:0]  OUT_ENABLE;
  int           err_total = 0;
  int           tests_run = 0;
  int           seed = 50954;
  int           cycles = 0;
  int           dlast = 0;
  int           sh[80] = '{default: 0};
  int           mat[80];
  logic [31:0]  r;
  always #25 CLK = ~CLK;
  xpt_host host (.clk(CLK), .sclk(sclk), .sdata(sdata), .cs_n(cs_n), .upd_n(upd_n),
    .mode(mode), .addr(addr), .pdata(pdata));
  xpt_program uut (.CLK(CLK), .SRST(SRST), .CLK_EN(1'b1), .SCLK(sclk), .DATA_IN(sdata),
    .CHIP_SEL_N(cs_n), .UPDATE_N(upd_n), .RESET_N(RESET_N), .MODE_SELECT_SERIAL_LOW(mode),
    .OUTPUT_ADDRESS_LINES(addr), .INPUT_SELECT_BITS(pdata[3:0]),
    .OUTPUT_ENABLE_BIT(pdata[4]), .DATA_OUT(DATA_OUT), .POINTS(POINTS),
    .OUT_ENABLE(OUT_ENABLE));
  task automatic check(input logic [255:0] seen, input logic [255:0] exp);
    tests_run++;
    if (seen !== exp) begin
      err_total++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic stop_test();
    $display("checks %0d errors %0d", tests_run, err_total);
    if (err_total == 0 && tests_run > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  always @(posedge CLK) begin
    cycles++;
    if (cycles == 5000) begin
      err_total++;
      stop_test();
    end
  end
  // Slot f of output o sits at 4-f: select bits go in before the enable
  task automatic ser(input logic d);
    int exp;
    exp = sh[79];
    host.shift(d);
    for (int j = 79; j > 0; j--) sh[j] = sh[j-1];
    sh[0] = d;
    dlast = exp;
    check(256'(DATA_OUT), 256'(exp[0]));
  endtask
  task automatic par(input logic [3:0] a, input logic [4:0] v);
    host.par(a, v);
    for (int f = 0; f < 5; f++) sh[a*5+4-f] = v[f];
  endtask
  task automatic expect_out();
    logic [255:0] p;
    logic [15:0]  e;
    p = '0;
    for (int o = 0; o < 16; o++) begin
      e[o] = mat[o*5][0];
      if (e[o]) p[o*16 + mat[o*5+4] + 2*mat[o*5+3] + 4*mat[o*5+2] + 8*mat[o*5+1]] = 1'b1;
    end
    check(POINTS, p);
    check(256'(OUT_ENABLE), 256'(e));
  endtask
  task automatic upd();
    host.update();
    mat = sh;
    expect_out();
  endtask
  initial begin
    repeat (4) @(negedge CLK);
    SRST = 1'b0;
    host.sel(1'b0);
    repeat (2) begin
      for (int n = 0; n < 80; n++) begin
        r = $random(seed);
        ser(r[0]);
      end
      upd();
    end
    r = $random(seed);
    par(4'h0, r[4:0]);
    par(4'hF, r[9:5]);
    upd();
    host.sel(1'b1);
    host.shift(~sh[78][0]);
    host.par(4'h3, ~r[14:10]);
    host.sel(1'b0);
    check(256'(DATA_OUT), 256'(dlast[0]));
    upd();
    RESET_N = 1'b0;
    repeat (6) @(negedge CLK);
    check(256'(OUT_ENABLE), 256'(16'h0000));
    RESET_N = 1'b1;
    upd();
    stop_test();
  end
endmodule
